// ### design/pctr_regs.sv
// PHY control and 10BASE-T status/control register bank with tuning registers.
// Summary of operation
// - Control word resets 003Fh at E4h.
// - Bit 11 picks long or short sequence.
// - Bit 10 latches result; control write clears.
// - Bit 9 runs self-test continuously until cleared.
// - Bit 8 bypasses LED pulse stretching.
// - Bit 7 shows both sides pause capable.
// - Bits 4:0 hold port address, reset ones.
// - 10BASE-T word resets 0004h at E8h.
// - Bit 8 ORed with basic-mode loopback.
// - Bit 7 stops normal link pulses.
// - Bit 6 or MAC force gives link.
// - Bit 5 forces inverted receive polarity.
// - Bit 4 latches polarity; either read clears.
// - Bit 3 turns automatic polarity correction off.
// - Bit 1 drops heartbeat only 10M half.
// - Bit 0 drops jabber only 10M full.
// - Registers decode at base plus offset.
module pctr_regs #(
  parameter logic [15:0] IO_BASE = 16'h0000,
  parameter int LED_STRETCH_CYCLES = pctr_pkg::LED_STRETCH_CYCLES
) (
  // Clock, reset and clock enable
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  // I/O register port
  input wire logic [15:0] io_addr_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic [15:0] io_wdata_in,
  output logic [15:0] io_rdata_out,
  // Status from the PHY datapath and MAC
  input wire logic local_pause_in,
  input wire logic partner_pause_in,
  input wire logic basic_mode_loopback_in,
  input wire logic mac_ten_meg_link_override_in,
  input wire logic link_status_in,
  input wire logic polarity_inverted_in,
  input wire logic phy_status_read_in,
  input wire logic speed_100_in,
  input wire logic full_duplex_in,
  input wire logic prbs_return_in,
  input wire logic [pctr_pkg::LED_COUNT-1:0] led_raw_in,
  // Controls to the PHY datapath
  output logic prbs_tx_out,
  output logic [pctr_pkg::LED_COUNT-1:0] led_out,
  output logic [4:0] port_mgmt_address_out,
  output logic ten_meg_loopback_out,
  output logic link_pulse_inhibit_out,
  output logic ten_meg_link_good_out,
  output logic polarity_invert_force_out,
  output logic polarity_flag_out,
  output logic auto_polarity_off_out,
  output logic sqe_test_enable_out,
  output logic jabber_guard_enable_out,
  output logic [15:0] dsp_setup_out,
  output logic [15:0] signal_detect_setup_out,
  output logic [15:0] test_data_port_out,
  output logic [15:0] pmd_control_alias_out
);

  // Control word fields.
  logic long_lfsr_select_ff;
  logic self_test_result_ff;
  logic self_test_run_ff;
  logic led_stretch_bypass_ff;
  logic pause_match_flag_ff;
  logic [4:0] port_mgmt_address_ff;
  // 10BASE-T word fields.
  logic ten_meg_loopback_ff;
  logic link_pulse_inhibit_ff;
  logic link_force_ff;
  logic polarity_invert_force_ff;
  logic polarity_flag_ff;
  logic auto_polarity_off_ff;
  logic sqe_test_off_ff;
  logic jabber_guard_off_ff;
  // Whole-word registers.
  logic [15:0] page_select_ff;
  logic [15:0] pmd_alias_ff;
  logic [15:0] dsp_setup_ff;
  logic [15:0] signal_detect_setup_ff;
  logic [15:0] test_data_ff;
  logic [15:0] rdata_ff;

  pctr_built_in_self_test_if built_in_self_test ();

  // Offset match relative to the I/O base.
  function automatic logic at_offset(input logic [15:0] addr, input logic [15:0] off);
    at_offset = (addr == 16'(IO_BASE + off));
  endfunction : at_offset

  wire logic pmd_page = (page_select_ff == pctr_pkg::PAGE_PMD);
  wire logic hit_page = at_offset(io_addr_in, pctr_pkg::OFF_PAGE_SELECT);
  wire logic hit_e4 = at_offset(io_addr_in, pctr_pkg::OFF_PHY_CONTROL);
  wire logic hit_ctrl = hit_e4 && !pmd_page;
  wire logic hit_pmd = hit_e4 && pmd_page;
  wire logic hit_tenbt = at_offset(io_addr_in, pctr_pkg::OFF_TENBASE);
  wire logic hit_dsp = at_offset(io_addr_in, pctr_pkg::OFF_DSP_SETUP);
  wire logic hit_sd = at_offset(io_addr_in, pctr_pkg::OFF_SIGDET_SETUP);
  wire logic hit_tdata = at_offset(io_addr_in, pctr_pkg::OFF_TEST_DATA);

  wire logic wr_ctrl = io_wr_in && hit_ctrl;
  wire logic wr_tenbt = io_wr_in && hit_tenbt;
  wire logic rd_tenbt = io_rd_in && hit_tenbt;

  // Reserved bits 6:5 keep their reset pattern; bits 15:12 read zero.
  wire logic [1:0] ctrl_rsv = pctr_pkg::RST_PHY_CONTROL[pctr_pkg::PC_RSV_HI:pctr_pkg::PC_RSV_LO];
  wire logic [15:0] ctrl_word = {4'h0, long_lfsr_select_ff, self_test_result_ff,
    self_test_run_ff, led_stretch_bypass_ff, pause_match_flag_ff, ctrl_rsv,
    port_mgmt_address_ff};
  wire logic must_one = pctr_pkg::RST_TENBASE[pctr_pkg::TB_MUST_ONE];
  wire logic [15:0] tenbt_word = {7'h00, ten_meg_loopback_ff, link_pulse_inhibit_ff,
    link_force_ff, polarity_invert_force_ff, polarity_flag_ff, auto_polarity_off_ff,
    must_one, sqe_test_off_ff, jabber_guard_off_ff};

  wire logic [15:0] read_mux =
    hit_page ? page_select_ff :
    hit_ctrl ? ctrl_word :
    hit_pmd ? pmd_alias_ff :
    hit_tenbt ? tenbt_word :
    hit_dsp ? dsp_setup_ff :
    hit_sd ? signal_detect_setup_ff :
    hit_tdata ? test_data_ff : 16'h0000;

  // Result: a failure sets it and wins over the clear from a control write.
  wire logic nxt_result = built_in_self_test.fail || (self_test_result_ff && !wr_ctrl);
  // Polarity: a new detection wins over the clear by either read.
  wire logic pol_clear = rd_tenbt || phy_status_read_in;
  wire logic nxt_pol = polarity_inverted_in || (polarity_flag_ff && !pol_clear);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      long_lfsr_select_ff <= pctr_pkg::RST_PHY_CONTROL[pctr_pkg::PC_LONG_LFSR];
      self_test_run_ff <= pctr_pkg::RST_PHY_CONTROL[pctr_pkg::PC_RUN];
      led_stretch_bypass_ff <= pctr_pkg::RST_PHY_CONTROL[pctr_pkg::PC_LED_BYPASS];
      port_mgmt_address_ff <= pctr_pkg::RST_PHY_CONTROL[pctr_pkg::PC_ADDR_HI:pctr_pkg::PC_ADDR_LO];
    end else if (ce_in && wr_ctrl) begin
      long_lfsr_select_ff <= io_wdata_in[pctr_pkg::PC_LONG_LFSR];
      self_test_run_ff <= io_wdata_in[pctr_pkg::PC_RUN];
      led_stretch_bypass_ff <= io_wdata_in[pctr_pkg::PC_LED_BYPASS];
      port_mgmt_address_ff <= io_wdata_in[pctr_pkg::PC_ADDR_HI:pctr_pkg::PC_ADDR_LO];
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      self_test_result_ff <= pctr_pkg::RST_PHY_CONTROL[pctr_pkg::PC_RESULT];
      pause_match_flag_ff <= pctr_pkg::RST_PHY_CONTROL[pctr_pkg::PC_PAUSE];
      polarity_flag_ff <= pctr_pkg::RST_TENBASE[pctr_pkg::TB_POL_FLAG];
      rdata_ff <= 16'h0000;
    end else if (ce_in) begin
      self_test_result_ff <= nxt_result;
      pause_match_flag_ff <= local_pause_in && partner_pause_in;
      polarity_flag_ff <= nxt_pol;
      if (io_rd_in) begin
        rdata_ff <= read_mux;
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ten_meg_loopback_ff <= pctr_pkg::RST_TENBASE[pctr_pkg::TB_LOOPBACK];
      link_pulse_inhibit_ff <= pctr_pkg::RST_TENBASE[pctr_pkg::TB_LP_INHIBIT];
      link_force_ff <= pctr_pkg::RST_TENBASE[pctr_pkg::TB_LINK_FORCE];
      polarity_invert_force_ff <= pctr_pkg::RST_TENBASE[pctr_pkg::TB_POL_FORCE];
      auto_polarity_off_ff <= pctr_pkg::RST_TENBASE[pctr_pkg::TB_AUTOPOL_OFF];
      sqe_test_off_ff <= pctr_pkg::RST_TENBASE[pctr_pkg::TB_SQE_OFF];
      jabber_guard_off_ff <= pctr_pkg::RST_TENBASE[pctr_pkg::TB_JABBER_OFF];
    end else if (ce_in && wr_tenbt) begin
      ten_meg_loopback_ff <= io_wdata_in[pctr_pkg::TB_LOOPBACK];
      link_pulse_inhibit_ff <= io_wdata_in[pctr_pkg::TB_LP_INHIBIT];
      link_force_ff <= io_wdata_in[pctr_pkg::TB_LINK_FORCE];
      polarity_invert_force_ff <= io_wdata_in[pctr_pkg::TB_POL_FORCE];
      auto_polarity_off_ff <= io_wdata_in[pctr_pkg::TB_AUTOPOL_OFF];
      sqe_test_off_ff <= io_wdata_in[pctr_pkg::TB_SQE_OFF];
      jabber_guard_off_ff <= io_wdata_in[pctr_pkg::TB_JABBER_OFF];
    end
  end

  // Tuning registers are plain storage handed to the analog front end.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      page_select_ff <= pctr_pkg::RST_PAGE_SELECT;
      pmd_alias_ff <= pctr_pkg::RST_PMD_ALIAS;
      dsp_setup_ff <= pctr_pkg::RST_DSP_SETUP;
      signal_detect_setup_ff <= pctr_pkg::RST_SIGDET_SETUP;
      test_data_ff <= pctr_pkg::RST_TEST_DATA;
    end else if (ce_in && io_wr_in) begin
      if (hit_page) begin
        page_select_ff <= io_wdata_in;
      end
      if (hit_pmd) begin
        pmd_alias_ff <= io_wdata_in;
      end
      if (hit_dsp) begin
        dsp_setup_ff <= io_wdata_in;
      end
      if (hit_sd) begin
        signal_detect_setup_ff <= io_wdata_in;
      end
      if (hit_tdata) begin
        test_data_ff <= io_wdata_in;
      end
    end
  end

  assign built_in_self_test.run = self_test_run_ff;
  assign built_in_self_test.long_sel = long_lfsr_select_ff;
  assign built_in_self_test.loop_bit = prbs_return_in;

  pctr_self_test u_self_test (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .ce_in(ce_in),
    .built_in_self_test(built_in_self_test.engine)
  );

  pctr_led_stretch #(
    .STRETCH_CYCLES(LED_STRETCH_CYCLES)
  ) u_led_stretch (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .ce_in(ce_in),
    .bypass_in(led_stretch_bypass_ff),
    .led_raw_in(led_raw_in),
    .led_out(led_out)
  );

  assign io_rdata_out = rdata_ff;
  assign prbs_tx_out = built_in_self_test.tx_bit;
  assign port_mgmt_address_out = port_mgmt_address_ff;
  assign ten_meg_loopback_out = ten_meg_loopback_ff || basic_mode_loopback_in;
  assign link_pulse_inhibit_out = link_pulse_inhibit_ff;
  assign ten_meg_link_good_out = link_force_ff || mac_ten_meg_link_override_in
    || link_status_in;
  assign polarity_invert_force_out = polarity_invert_force_ff;
  assign polarity_flag_out = polarity_flag_ff;
  assign auto_polarity_off_out = auto_polarity_off_ff;
  // Heartbeat only exists in 10 Mb/s half duplex; the bit cannot turn it on elsewhere.
  assign sqe_test_enable_out = !speed_100_in && !full_duplex_in && !sqe_test_off_ff;
  assign jabber_guard_enable_out = !(jabber_guard_off_ff && full_duplex_in
    && !speed_100_in);
  assign dsp_setup_out = dsp_setup_ff;
  assign signal_detect_setup_out = signal_detect_setup_ff;
  assign test_data_port_out = test_data_ff;
  assign pmd_control_alias_out = pmd_alias_ff;

  a_result_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ce_in && wr_ctrl && !built_in_self_test.fail |=> !self_test_result_ff)
    else $error("Self-test result not cleared by control write.");

  a_result_latched: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    self_test_result_ff && !(ce_in && wr_ctrl) |=> self_test_result_ff)
    else $error("Self-test result dropped without a control write.");

  a_run_follows: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ce_in && wr_ctrl |=> built_in_self_test.run == $past(io_wdata_in[pctr_pkg::PC_RUN]))
    else $error("Self-test run does not follow written bit.");

  a_pause_match: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ce_in |=> io_rd_in || (ctrl_word[pctr_pkg::PC_PAUSE] ==
      $past(local_pause_in && partner_pause_in)))
    else $error("Pause match flag wrong.");

  a_polarity_set: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ce_in && polarity_inverted_in |=> polarity_flag_out ##0 tenbt_word[pctr_pkg::TB_POL_FLAG])
    else $error("Polarity detection lost.");

  a_polarity_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ce_in && pol_clear && !polarity_inverted_in |=> !polarity_flag_out)
    else $error("Polarity flag not cleared by read.");

  a_ctrl_readback: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ce_in && io_rd_in && hit_ctrl |=> io_rdata_out == $past(ctrl_word))
    else $error("Control word read returned wrong data.");

  a_tenbt_readback: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ce_in && io_rd_in && hit_tenbt |=> io_rdata_out[15:9] == 7'h00
      && io_rdata_out[pctr_pkg::TB_MUST_ONE])
    else $error("10BASE-T word reserved bits read wrong.");

  a_sqe_gate: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    speed_100_in || full_duplex_in |-> !sqe_test_enable_out)
    else $error("Heartbeat enabled outside 10 Mb/s half duplex.");

  a_jabber_gate: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !full_duplex_in || speed_100_in |-> jabber_guard_enable_out)
    else $error("Jabber disabled outside 10 Mb/s full duplex.");

  a_link_force: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ce_in && wr_tenbt && io_wdata_in[pctr_pkg::TB_LINK_FORCE] |=> ten_meg_link_good_out)
    else $error("Forced link not reported good.");

  a_loop_or: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ce_in && wr_tenbt && io_wdata_in[pctr_pkg::TB_LOOPBACK] |=> ten_meg_loopback_out)
    else $error("Loopback not enabled by register bit.");

endmodule : pctr_regs

// ### design/pctr_pkg.sv
// Constants shared by the PHY control and 10BASE-T register bank.
package pctr_pkg;

  // Register offsets from the I/O base address.
  localparam logic [15:0] OFF_PAGE_SELECT = 16'h00cc;
  localparam logic [15:0] OFF_PHY_CONTROL = 16'h00e4;
  localparam logic [15:0] OFF_TENBASE = 16'h00e8;
  localparam logic [15:0] OFF_DSP_SETUP = 16'h00f4;
  localparam logic [15:0] OFF_SIGDET_SETUP = 16'h00f8;
  localparam logic [15:0] OFF_TEST_DATA = 16'h00fc;

  // Page that turns the control word offset into the PMD alias.
  localparam logic [15:0] PAGE_PMD = 16'h0001;

  // Reset values.
  localparam logic [15:0] RST_PHY_CONTROL = 16'h003f;
  localparam logic [15:0] RST_TENBASE = 16'h0004;
  localparam logic [15:0] RST_PAGE_SELECT = 16'h0000;
  localparam logic [15:0] RST_PMD_ALIAS = 16'h0000;
  localparam logic [15:0] RST_DSP_SETUP = 16'h0000;
  localparam logic [15:0] RST_SIGDET_SETUP = 16'h0000;
  localparam logic [15:0] RST_TEST_DATA = 16'h0000;

  // PHY control word fields.
  localparam int PC_LONG_LFSR = 11;
  localparam int PC_RESULT = 10;
  localparam int PC_RUN = 9;
  localparam int PC_LED_BYPASS = 8;
  localparam int PC_PAUSE = 7;
  localparam int PC_RSV_HI = 6;
  localparam int PC_RSV_LO = 5;
  localparam int PC_ADDR_HI = 4;
  localparam int PC_ADDR_LO = 0;

  // 10BASE-T status and control word fields.
  localparam int TB_LOOPBACK = 8;
  localparam int TB_LP_INHIBIT = 7;
  localparam int TB_LINK_FORCE = 6;
  localparam int TB_POL_FORCE = 5;
  localparam int TB_POL_FLAG = 4;
  localparam int TB_AUTOPOL_OFF = 3;
  localparam int TB_MUST_ONE = 2;
  localparam int TB_SQE_OFF = 1;
  localparam int TB_JABBER_OFF = 0;

  // Self-test sequence lengths.
  localparam int PRBS_LONG_LEN = 15;
  localparam int PRBS_SHORT_LEN = 9;

  // LED pulse stretching.
  localparam int CLK_HZ = 20_000_000;
  localparam int LED_STRETCH_MS = 50;
  localparam int LED_STRETCH_CYCLES = LED_STRETCH_MS * (CLK_HZ / 1000);
  localparam int LED_COUNT = 3;

  // Self-test engine states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PRIME = 3'b010,
    ST_CHECK = 3'b100
  } pctr_built_in_self_test_state_t;

endpackage : pctr_pkg

// ### design/pctr_built_in_self_test_if.sv
// Signals between the register bank and its self-test engine.
interface pctr_built_in_self_test_if;
  logic run;
  logic long_sel;
  logic loop_bit;
  logic tx_bit;
  logic fail;

  modport ctrl (output run, output long_sel, output loop_bit, input tx_bit, input fail);
  modport engine (input run, input long_sel, input loop_bit, output tx_bit, output fail);
endinterface : pctr_built_in_self_test_if

// ### design/pctr_self_test.sv
// Pseudo-random self-test pattern generator and self-synchronising checker.
module pctr_self_test (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  // Control side
  pctr_built_in_self_test_if.engine built_in_self_test
);

  logic [14:0] gen_ff;
  logic [14:0] nxt_gen;
  logic [14:0] chk_ff;
  logic [3:0] prime_ff;
  logic [3:0] nxt_prime;
  logic fail_ff;
  pctr_pkg::pctr_built_in_self_test_state_t state_ff;
  pctr_pkg::pctr_built_in_self_test_state_t nxt_state;
  wire logic predicted;
  wire logic mismatch;

  // Feedback of either sequence; the short one uses only the low nine stages.
  function automatic logic prbs_fb(input logic [14:0] s, input logic long_sel);
    prbs_fb = long_sel ? (s[14] ^ s[13]) : (s[8] ^ s[4]);
  endfunction : prbs_fb

  assign nxt_gen = built_in_self_test.run ? {gen_ff[13:0], prbs_fb(gen_ff, built_in_self_test.long_sel)} : '1;
  assign predicted = prbs_fb(chk_ff, built_in_self_test.long_sel);
  // A stopped test must not report the stray bits that arrive while the loop winds down.
  assign mismatch = (state_ff == pctr_pkg::ST_CHECK) && built_in_self_test.run && (built_in_self_test.loop_bit != predicted);
  assign built_in_self_test.tx_bit = gen_ff[0];
  assign built_in_self_test.fail = fail_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_prime = prime_ff;
    unique case (state_ff)
      pctr_pkg::ST_IDLE: begin
        nxt_prime = '0;
        if (built_in_self_test.run) begin
          nxt_state = pctr_pkg::ST_PRIME;
        end
      end
      pctr_pkg::ST_PRIME: begin
        // The checker must fill its shift register before predictions mean anything.
        nxt_prime = prime_ff + 4'h1;
        if (!built_in_self_test.run) begin
          nxt_state = pctr_pkg::ST_IDLE;
        end else if (prime_ff == 4'(pctr_pkg::PRBS_LONG_LEN)) begin
          nxt_state = pctr_pkg::ST_CHECK;
        end
      end
      pctr_pkg::ST_CHECK: begin
        if (!built_in_self_test.run) begin
          nxt_state = pctr_pkg::ST_IDLE;
        end
      end
      default: nxt_state = pctr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_ff <= pctr_pkg::ST_IDLE;
      gen_ff <= '1;
      chk_ff <= '0;
      prime_ff <= '0;
      fail_ff <= 1'b0;
    end else if (ce_in) begin
      state_ff <= nxt_state;
      gen_ff <= nxt_gen;
      chk_ff <= {chk_ff[13:0], built_in_self_test.loop_bit};
      prime_ff <= nxt_prime;
      fail_ff <= mismatch;
    end
  end

endmodule : pctr_self_test

// ### design/pctr_led_stretch.sv
// Stretches short LED activity pulses, with a bypass that passes the raw input through one register.
module pctr_led_stretch #(
  parameter int STRETCH_CYCLES = pctr_pkg::LED_STRETCH_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  // Control
  input wire logic bypass_in,
  // LEDs
  input wire logic [pctr_pkg::LED_COUNT-1:0] led_raw_in,
  output logic [pctr_pkg::LED_COUNT-1:0] led_out
);

  localparam int CW = $clog2(STRETCH_CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(STRETCH_CYCLES);

  logic [CW-1:0] hold_ff [pctr_pkg::LED_COUNT];
  logic [pctr_pkg::LED_COUNT-1:0] led_ff;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < pctr_pkg::LED_COUNT; i++) begin
        hold_ff[i] <= '0;
      end
      led_ff <= '0;
    end else if (ce_in) begin
      for (int i = 0; i < pctr_pkg::LED_COUNT; i++) begin
        if (led_raw_in[i]) begin
          hold_ff[i] <= LOAD;
        end else if (hold_ff[i] != '0) begin
          hold_ff[i] <= hold_ff[i] - CW'(1);
        end
        // Bypass shows the raw input with only one register of delay.
        led_ff[i] <= bypass_in ? led_raw_in[i] : (led_raw_in[i] || hold_ff[i] != '0);
      end
    end
  end

  assign led_out = led_ff;

endmodule : pctr_led_stretch

// ### test/pctr_regs_bench.sv
// Self-checking bench for the PHY control and 10BASE-T register bank.
module pctr_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] BASE = 16'h0100;
  logic clk_in, reset_n_in, ce_in, io_wr_in, io_rd_in;
  logic [15:0] io_addr_in, io_wdata_in, io_rdata_out;
  logic local_pause_in, partner_pause_in, basic_mode_loopback_in, mac_ten_meg_link_override_in;
  logic link_status_in, polarity_inverted_in, phy_status_read_in, speed_100_in;
  logic full_duplex_in, prbs_return_in, prbs_tx_out, ten_meg_loopback_out;
  logic link_pulse_inhibit_out, ten_meg_link_good_out, polarity_invert_force_out;
  logic polarity_flag_out, auto_polarity_off_out, sqe_test_enable_out, jabber_guard_enable_out;
  logic [pctr_pkg::LED_COUNT-1:0] led_raw_in, led_out;
  logic [4:0] port_mgmt_address_out;
  logic [15:0] dsp_setup_out, signal_detect_setup_out, test_data_port_out, pmd_control_alias_out;
  logic loop_mode, rnd_bit;
  logic rd_seen = 1'b0;
  logic [31:0] seed = 32'h0000b99f;
  logic [15:0] exp_q[$];
  int n_fail = 0;
  int checked = 0;

  pctr_regs #(.IO_BASE(BASE), .LED_STRETCH_CYCLES(8)) i_dut (.*);

  // Looping the pattern back makes a clean run; random bits make it fail.
  assign prbs_return_in = loop_mode ? prbs_tx_out : rnd_bit;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    if (n_fail == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  task automatic wr(input logic [15:0] off, input logic [15:0] d);
    @(negedge clk_in);
    io_wr_in = 1'b1;
    io_addr_in = BASE + off;
    io_wdata_in = d;
    @(negedge clk_in);
    io_wr_in = 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] off, input logic [15:0] e);
    @(negedge clk_in);
    io_rd_in = 1'b1;
    io_addr_in = BASE + off;
    exp_q.push_back(e);
    @(negedge clk_in);
    io_rd_in = 1'b0;
  endtask : rd

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  always @(negedge clk_in) rnd_bit <= ^xs();
  always @(posedge clk_in) rd_seen <= io_rd_in & ce_in;
  always @(negedge clk_in) begin
    if (rd_seen) begin
      chk(io_rdata_out, exp_q.pop_front());
    end
  end

  initial begin
    #3_000_000;
    n_fail++;
    results();
  end

  initial begin : main
    logic [15:0] d;
    logic [2:0] r;
    {ce_in, loop_mode} = 2'b11;
    {reset_n_in, io_wr_in, io_rd_in, local_pause_in, partner_pause_in} = 5'h00;
    {basic_mode_loopback_in, mac_ten_meg_link_override_in, link_status_in} = 3'h0;
    {polarity_inverted_in, phy_status_read_in, speed_100_in, full_duplex_in} = 4'h0;
    {io_addr_in, io_wdata_in, led_raw_in} = '0;
    repeat (16) @(negedge clk_in);
    reset_n_in = 1'b1;
    rd(16'h00e4, 16'h003f);
    rd(16'h00e8, 16'h0004);
    rd(16'h00cc, 16'h0000);
    rd(16'h00f4, 16'h0000);
    rd(16'h00f8, 16'h0000);
    rd(16'h00fc, 16'h0000);
    rd(16'h00e0, 16'h0000);
    rd(16'h00e4 - BASE, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_in);
      {local_pause_in, partner_pause_in} = 2'(i);
      rd(16'h00e4, {8'h00, i == 3, 7'h3f});
    end
    {local_pause_in, partner_pause_in} = 2'b00;
    wr(16'h00e4, 16'hfdf2);
    rd(16'h00e4, 16'h0932);
    chk(16'(port_mgmt_address_out), 16'h0012);
    led_raw_in = 3'h5;
    repeat (2) @(negedge clk_in);
    chk(16'(led_out), 16'h0005);
    led_raw_in = 3'h0;
    wr(16'h00e4, 16'h001f);
    repeat (12) @(negedge clk_in);
    led_raw_in = 3'h7;
    @(negedge clk_in);
    led_raw_in = 3'h0;
    repeat (3) @(negedge clk_in);
    chk(16'(led_out), 16'h0007);
    repeat (20) @(negedge clk_in);
    chk(16'(led_out), 16'h0000);
    for (int i = 0; i < 2; i++) begin
      loop_mode = 1'b1;
      wr(16'h00e4, {4'h0, i[0], 11'h21f});
      repeat (20000) @(negedge clk_in);
      rd(16'h00e4, {4'h0, i[0], 11'h23f});
      loop_mode = 1'b0;
      repeat (40) @(negedge clk_in);
      rd(16'h00e4, {4'h0, i[0], 11'h63f});
      wr(16'h00e4, 16'h001f);
      // A bad bit caught just before the stop still lands, so a second write clears it.
      wr(16'h00e4, 16'h001f);
      rd(16'h00e4, 16'h003f);
    end
    repeat (8) begin
      d = 16'(xs()) | 16'h0004;
      r = 3'(xs());
      {basic_mode_loopback_in, mac_ten_meg_link_override_in, link_status_in} = r;
      {speed_100_in, full_duplex_in} = 2'(xs());
      wr(16'h00e8, d);
      rd(16'h00e8, (d & 16'h01ef) | 16'h0004);
      chk(16'(ten_meg_loopback_out), 16'(d[8] | r[2]));
      chk(16'(link_pulse_inhibit_out), 16'(d[7]));
      chk(16'(ten_meg_link_good_out), 16'(d[6] | r[1] | r[0]));
      chk(16'(polarity_invert_force_out), 16'(d[5]));
      chk(16'(auto_polarity_off_out), 16'(d[3]));
      chk(16'(sqe_test_enable_out), 16'(!speed_100_in && !full_duplex_in && !d[1]));
      chk(16'(jabber_guard_enable_out), 16'(!(d[0] && full_duplex_in && !speed_100_in)));
    end
    for (int i = 0; i < 2; i++) begin
      polarity_inverted_in = 1'b1;
      @(negedge clk_in);
      polarity_inverted_in = 1'b0;
      @(negedge clk_in);
      chk(16'(polarity_flag_out), 16'h0001);
      if (i == 0) begin
        rd(16'h00e8, (d & 16'h01ef) | 16'h0014);
        rd(16'h00e8, (d & 16'h01ef) | 16'h0004);
      end else begin
        phy_status_read_in = 1'b1;
        @(negedge clk_in);
        phy_status_read_in = 1'b0;
        @(negedge clk_in);
        chk(16'(polarity_flag_out), 16'h0000);
      end
    end
    wr(16'h00fc, 16'ha5c3);
    wr(16'h00cc, 16'h0001);
    wr(16'h00e4, 16'h189c);
    wr(16'h00fc, 16'h0000);
    wr(16'h00f4, 16'h5040);
    wr(16'h00f8, 16'h008c);
    rd(16'h00e4, 16'h189c);
    rd(16'h00cc, 16'h0001);
    chk(pmd_control_alias_out, 16'h189c);
    chk(dsp_setup_out, 16'h5040);
    chk(signal_detect_setup_out, 16'h008c);
    chk(test_data_port_out, 16'h0000);
    wr(16'h00cc, 16'h0000);
    rd(16'h00e4, 16'h003f);
    // A write while the clock enable is low must leave the word untouched.
    ce_in = 1'b0;
    wr(16'h00e4, 16'h0000);
    ce_in = 1'b1;
    rd(16'h00e4, 16'h003f);
    wr(16'h00e8, 16'h01ef);
    reset_n_in = 1'b0;
    repeat (2) @(negedge clk_in);
    reset_n_in = 1'b1;
    rd(16'h00e8, 16'h0004);
    repeat (4) @(negedge clk_in);
    results();
  end
endmodule : pctr_regs_bench
